//--- rtl/bbbs_consts.svh
`ifndef BBBS_CONSTS_SVH
`define BBBS_CONSTS_SVH

// ==========================================================
// Clock rate
`define BBBS_CLK_KHZ              250000

// ==========================================================
// Button timing, in milliseconds, then in clock cycles
`define BBBS_CLICK_WINDOW_MS      500
`define BBBS_HOLD_MS              3000
`define BBBS_DEBOUNCE_MS          5
`define BBBS_CLICK_WINDOW_CYCLES  (`BBBS_CLICK_WINDOW_MS * `BBBS_CLK_KHZ)
`define BBBS_HOLD_CYCLES          (`BBBS_HOLD_MS * `BBBS_CLK_KHZ)
`define BBBS_DEBOUNCE_CYCLES      (`BBBS_DEBOUNCE_MS * `BBBS_CLK_KHZ)

// ==========================================================
// Counter widths and click limits
`define BBBS_TIMER_W              30
`define BBBS_DEB_W                21
`define BBBS_CLICK_W              3
`define BBBS_CLICKS_CANCEL        3'h4
`define BBBS_PWM_W                8

// ==========================================================
// Boot switch codes, position 4 most significant
`define BBBS_CODE_ARM_NAND        4'h0
`define BBBS_CODE_DSP_NOBOOT_A    4'h1
`define BBBS_CODE_ARM_SPI         4'h2
`define BBBS_CODE_ARM_I2C         4'h3
`define BBBS_CODE_ARM_UART        4'h4
`define BBBS_CODE_ARM_ETH         4'h5
`define BBBS_CODE_SLP_MAX_BYP     4'h6
`define BBBS_CODE_SLP_MAX         4'h7
`define BBBS_CODE_DSP_NAND        4'h8
`define BBBS_CODE_SLP_SLOW_BYP    4'h9
`define BBBS_CODE_DSP_SPI         4'hA
`define BBBS_CODE_DSP_I2C         4'hB
`define BBBS_CODE_DSP_UART        4'hC
`define BBBS_CODE_DSP_ETH         4'hD
`define BBBS_CODE_SLP_SLOW_SLOW   4'hE
`define BBBS_CODE_DSP_NOBOOT_B    4'hF

`endif

//--- rtl/bbbs_pkg.sv
// ==========================================================
// Types shared by the button and boot select logic
package bbbs_pkg;

   // Decoded processor boot selection
   typedef enum logic [3:0] {
      BBBS_BOOT_ARM_NAND,
      BBBS_BOOT_ARM_SPI,
      BBBS_BOOT_ARM_I2C,
      BBBS_BOOT_ARM_UART,
      BBBS_BOOT_ARM_ETH,
      BBBS_BOOT_DSP_NAND,
      BBBS_BOOT_DSP_SPI,
      BBBS_BOOT_DSP_I2C,
      BBBS_BOOT_DSP_UART,
      BBBS_BOOT_DSP_ETH,
      BBBS_BOOT_DSP_NO_BOOT,
      BBBS_BOOT_SLEEP_MAX_PLL_ARM_BYPASS,
      BBBS_BOOT_SLEEP_MAX_PLL,
      BBBS_BOOT_SLEEP_SLOW_PLL_ARM_BYPASS,
      BBBS_BOOT_SLEEP_SLOW_PLL_SLOW_ARM_PLL
   } bbbs_boot_type;

   // Power button click tracker states
   typedef enum logic [1:0] {
      BBBS_ST_IDLE,
      BBBS_ST_PRESSED,
      BBBS_ST_RELEASED,
      BBBS_ST_WAIT_RELEASE
   } bbbs_click_state_type;

endpackage

//--- rtl/bbbs_debounce.sv
`timescale 1ns/10ps
`include "bbbs_consts.svh"

// ==========================================================
// Debouncer: output follows input once it has held steady
module bbbs_debounce #(
   parameter int unsigned SETTLE_CYCLES = `BBBS_DEBOUNCE_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic raw_in,
   output logic      level_out
);
   import bbbs_pkg::*;

   typedef struct packed {
      logic                   level;
      logic [`BBBS_DEB_W-1:0] count;
   } bbbs_deb_state_type;

   bbbs_deb_state_type state_reg;
   bbbs_deb_state_type state_next;

   // Count cycles the input disagrees; bounce restarts the count
   always_comb begin
      state_next = state_reg;
      if (raw_in == state_reg.level) begin
         state_next.count = '0;
      end else if (state_reg.count >=
                   `BBBS_DEB_W'(SETTLE_CYCLES - 1)) begin
         state_next.level = raw_in;
         state_next.count = '0;
      end else begin
         state_next.count = state_reg.count + `BBBS_DEB_W'(1);
      end
   end

   // State register
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign level_out = state_reg.level;

endmodule // bbbs_debounce

//--- rtl/bbbs_top.sv
// Summary of operation
// - A press counts in the sequence if it starts within 0.5 s of last press
// - Sequence ending at one press starts a graceful shutdown
// - Sequence ending at two presses performs a warm reset
// - Sequence ending at three presses performs a full reset
// - Sequence ending at four presses cancels and does nothing
// - Power button held over 3 s forces immediate shutdown
// - Controller reset button asserts controller reset and peripheral reset
// - Codes 0000,0010,0011,0100,0101 pick ARM NAND/SPI/I2C/UART/Ethernet
// - Codes 1000,1010,1011,1100,1101 pick DSP NAND/SPI/I2C/UART/Ethernet
// - Codes 0001 and 1111 both pick DSP no-boot
// - Code 0110 sleep max PLL with ARM bypass; 0111 sleep max PLL
// - Code 1001 sleep slow PLL, ARM bypass; 1110 slow PLL, slow ARM PLL
// - Attached external debugger takes debug port from on-board emulator
// - Fan speed set by PWM duty cycle
`timescale 1ns/10ps
`include "bbbs_consts.svh"

module bbbs_top #(
   parameter int unsigned CLICK_WINDOW_CYCLES = `BBBS_CLICK_WINDOW_CYCLES,
   parameter int unsigned HOLD_CYCLES         = `BBBS_HOLD_CYCLES,
   parameter int unsigned DEBOUNCE_CYCLES     = `BBBS_DEBOUNCE_CYCLES
) (
   input  wire logic                     clk_in,
   input  wire logic                     resetn_in,
   input  wire logic                     power_button_n_in,
   input  wire logic                     controller_reset_button_n_in,
   input  wire logic [3:0]               boot_mode_switch_in,
   input  wire logic                     external_debugger_detect_in,
   input  wire logic [`BBBS_PWM_W-1:0]   fan_duty_in,
   output logic                          graceful_shutdown_out,
   output logic                          warm_reset_out,
   output logic                          full_reset_out,
   output logic                          forced_shutdown_out,
   output logic                          click_cancel_out,
   output logic [`BBBS_CLICK_W-1:0]      click_count_out,
   output logic                          board_management_controller_rst_n_out,
   output logic                          peripheral_reset_out,
   output bbbs_pkg::bbbs_boot_type       boot_mode_out,
   output logic                          boot_dsp_out,
   output logic                          onboard_emulator_connect_out,
   output logic                          trace_debug_header_select_out,
   output logic                          fan_pwm_out
);
   import bbbs_pkg::*;

   // =======================================================
   // State of the block
   typedef struct packed {
      bbbs_click_state_type      click_state;
      logic [`BBBS_CLICK_W-1:0]  clicks;
      logic [`BBBS_TIMER_W-1:0]  timer;
      logic                      graceful;
      logic                      warm;
      logic                      full;
      logic                      forced;
      logic                      cancel;
      logic                      ctl_rst_n;
      logic                      periph_rst;
      bbbs_boot_type             boot;
      logic                      boot_dsp;
      logic                      onboard_emu;
      logic                      ext_header;
      logic [`BBBS_PWM_W-1:0]    pwm_count;
      logic                      pwm;
   } bbbs_state_type;

   bbbs_state_type state_reg;
   bbbs_state_type state_next;

   logic power_pressed;
   logic ctl_reset_pressed;
   logic window_over;
   logic hold_over;

   // =======================================================
   // Button debouncing
   bbbs_debounce #(
      .SETTLE_CYCLES (DEBOUNCE_CYCLES)
   ) u_power_debounce (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .raw_in    (~power_button_n_in),
      .level_out (power_pressed)
   );

   bbbs_debounce #(
      .SETTLE_CYCLES (DEBOUNCE_CYCLES)
   ) u_ctl_reset_debounce (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .raw_in    (~controller_reset_button_n_in),
      .level_out (ctl_reset_pressed)
   );

   // Timer measures cycles since the start of the latest press
   assign window_over = state_reg.timer >
                        `BBBS_TIMER_W'(CLICK_WINDOW_CYCLES);
   assign hold_over   = state_reg.timer >=
                        `BBBS_TIMER_W'(HOLD_CYCLES);

   // =======================================================
   // Next state
   always_comb begin
      state_next          = state_reg;
      state_next.graceful = 1'b0;
      state_next.warm     = 1'b0;
      state_next.full     = 1'b0;
      state_next.forced   = 1'b0;
      state_next.cancel   = 1'b0;

      // Saturating press timer
      if (state_reg.timer != {`BBBS_TIMER_W{1'b1}}) begin
         state_next.timer = state_reg.timer + `BBBS_TIMER_W'(1);
      end

      // Power button click tracker
      case (state_reg.click_state)
         BBBS_ST_IDLE: begin
            state_next.clicks = '0;
            if (power_pressed) begin
               state_next.clicks      = `BBBS_CLICK_W'(1);
               state_next.timer       = '0;
               state_next.click_state = BBBS_ST_PRESSED;
            end
         end
         BBBS_ST_PRESSED: begin
            if (hold_over) begin
               state_next.forced      = 1'b1;
               state_next.clicks      = '0;
               state_next.click_state = BBBS_ST_WAIT_RELEASE;
            end else if (!power_pressed) begin
               state_next.click_state = BBBS_ST_RELEASED;
            end
         end
         BBBS_ST_RELEASED: begin
            if (power_pressed && !window_over) begin
               // Follow-on press joins the sequence
               if (state_reg.clicks < `BBBS_CLICKS_CANCEL) begin
                  state_next.clicks = state_reg.clicks +
                                      `BBBS_CLICK_W'(1);
               end
               state_next.timer       = '0;
               state_next.click_state = BBBS_ST_PRESSED;
            end else if (window_over) begin
               // Sequence closed: act on the count
               state_next.click_state = BBBS_ST_IDLE;
               case (state_reg.clicks)
                  `BBBS_CLICK_W'(1): state_next.graceful = 1'b1;
                  `BBBS_CLICK_W'(2): state_next.warm     = 1'b1;
                  `BBBS_CLICK_W'(3): state_next.full     = 1'b1;
                  default:           state_next.cancel   = 1'b1;
               endcase
            end
         end
         BBBS_ST_WAIT_RELEASE: begin
            if (!power_pressed) begin
               state_next.click_state = BBBS_ST_IDLE;
            end
         end
         default: begin
            state_next.click_state = BBBS_ST_IDLE;
         end
      endcase

      // Controller reset follows the reset button
      state_next.ctl_rst_n  = ~ctl_reset_pressed;
      state_next.periph_rst = ctl_reset_pressed;

      // Boot switch decode
      state_next.boot_dsp = 1'b0;
      case (boot_mode_switch_in)
         `BBBS_CODE_ARM_NAND:
            state_next.boot = BBBS_BOOT_ARM_NAND;
         `BBBS_CODE_ARM_SPI:
            state_next.boot = BBBS_BOOT_ARM_SPI;
         `BBBS_CODE_ARM_I2C:
            state_next.boot = BBBS_BOOT_ARM_I2C;
         `BBBS_CODE_ARM_UART:
            state_next.boot = BBBS_BOOT_ARM_UART;
         `BBBS_CODE_ARM_ETH:
            state_next.boot = BBBS_BOOT_ARM_ETH;
         `BBBS_CODE_DSP_NAND: begin
            state_next.boot     = BBBS_BOOT_DSP_NAND;
            state_next.boot_dsp = 1'b1;
         end
         `BBBS_CODE_DSP_SPI: begin
            state_next.boot     = BBBS_BOOT_DSP_SPI;
            state_next.boot_dsp = 1'b1;
         end
         `BBBS_CODE_DSP_I2C: begin
            state_next.boot     = BBBS_BOOT_DSP_I2C;
            state_next.boot_dsp = 1'b1;
         end
         `BBBS_CODE_DSP_UART: begin
            state_next.boot     = BBBS_BOOT_DSP_UART;
            state_next.boot_dsp = 1'b1;
         end
         `BBBS_CODE_DSP_ETH: begin
            state_next.boot     = BBBS_BOOT_DSP_ETH;
            state_next.boot_dsp = 1'b1;
         end
         `BBBS_CODE_DSP_NOBOOT_A, `BBBS_CODE_DSP_NOBOOT_B: begin
            state_next.boot     = BBBS_BOOT_DSP_NO_BOOT;
            state_next.boot_dsp = 1'b1;
         end
         `BBBS_CODE_SLP_MAX_BYP:
            state_next.boot = BBBS_BOOT_SLEEP_MAX_PLL_ARM_BYPASS;
         `BBBS_CODE_SLP_MAX:
            state_next.boot = BBBS_BOOT_SLEEP_MAX_PLL;
         `BBBS_CODE_SLP_SLOW_BYP:
            state_next.boot = BBBS_BOOT_SLEEP_SLOW_PLL_ARM_BYPASS;
         `BBBS_CODE_SLP_SLOW_SLOW:
            state_next.boot = BBBS_BOOT_SLEEP_SLOW_PLL_SLOW_ARM_PLL;
         default:
            state_next.boot = BBBS_BOOT_DSP_NO_BOOT;
      endcase

      // Debug port routing
      state_next.onboard_emu = ~external_debugger_detect_in;
      state_next.ext_header  = external_debugger_detect_in;

      // Fan PWM, period of 256 cycles
      state_next.pwm_count = state_reg.pwm_count + `BBBS_PWM_W'(1);
      state_next.pwm       = state_reg.pwm_count < fan_duty_in;
   end

   // =======================================================
   // State register
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state_reg             <= '0;
         state_reg.click_state <= BBBS_ST_IDLE;
         state_reg.ctl_rst_n   <= 1'b1;
         state_reg.boot        <= BBBS_BOOT_DSP_NO_BOOT;
         state_reg.onboard_emu <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // =======================================================
   // Outputs
   assign graceful_shutdown_out                 = state_reg.graceful;
   assign warm_reset_out                        = state_reg.warm;
   assign full_reset_out                        = state_reg.full;
   assign forced_shutdown_out                   = state_reg.forced;
   assign click_cancel_out                      = state_reg.cancel;
   assign click_count_out                       = state_reg.clicks;
   assign board_management_controller_rst_n_out = state_reg.ctl_rst_n;
   assign peripheral_reset_out                  = state_reg.periph_rst;
   assign boot_mode_out                         = state_reg.boot;
   assign boot_dsp_out                          = state_reg.boot_dsp;
   assign onboard_emulator_connect_out          = state_reg.onboard_emu;
   assign trace_debug_header_select_out         = state_reg.ext_header;
   assign fan_pwm_out                           = state_reg.pwm;

endmodule // bbbs_top

//--- verification/bbbs_panel_model.sv
`timescale 1ns/10ps
// ============================================================
// Front panel: two push buttons whose contacts bounce
module bbbs_panel_model (
   input  wire logic clk_in,
   input  wire logic press_power_in,
   input  wire logic press_reset_in,
   output logic      power_button_n_out,
   output logic      controller_reset_button_n_out
);
   logic [1:0] pwr_ring_reg = 2'h0;
   logic [1:0] rst_ring_reg = 2'h0;
   logic       pwr_last_reg = 1'b0;
   logic       rst_last_reg = 1'b0;

   // Each change rings for two one-cycle glitches, then settles
   always @(posedge clk_in) begin
      pwr_last_reg <= press_power_in;
      rst_last_reg <= press_reset_in;
      if (press_power_in != pwr_last_reg) pwr_ring_reg <= 2'h3;
      else if (pwr_ring_reg != 2'h0) pwr_ring_reg <= pwr_ring_reg - 2'h1;
      if (press_reset_in != rst_last_reg) rst_ring_reg <= 2'h3;
      else if (rst_ring_reg != 2'h0) rst_ring_reg <= rst_ring_reg - 2'h1;
   end

   // Buttons pull low while pressed
   assign power_button_n_out = !press_power_in ^ pwr_ring_reg[0];
   assign controller_reset_button_n_out = !press_reset_in ^ rst_ring_reg[0];
endmodule // bbbs_panel_model

//--- verification/bbbs_top_assertions.sv
`timescale 1ns/10ps
// ============================================================
// Checker on the ports of the button and boot select block
module bbbs_top_assertions #(
   parameter int unsigned DEBOUNCE_CYCLES = 4
) (
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic       controller_reset_button_n_in,
   input  wire logic [3:0] boot_mode_switch_in,
   input  wire logic       external_debugger_detect_in,
   input  wire logic [7:0] fan_duty_in,
   input  wire logic       graceful_shutdown_out,
   input  wire logic       warm_reset_out,
   input  wire logic       full_reset_out,
   input  wire logic       forced_shutdown_out,
   input  wire logic       click_cancel_out,
   input  wire logic [2:0] click_count_out,
   input  wire logic       board_management_controller_rst_n_out,
   input  wire logic       peripheral_reset_out,
   input  wire logic       boot_dsp_out,
   input  wire logic       onboard_emulator_connect_out,
   input  wire logic       trace_debug_header_select_out,
   input  wire logic       fan_pwm_out
);
   localparam logic [15:0] DSP_MASK = 16'hBD02;
   localparam logic        FAST     = (DEBOUNCE_CYCLES <= 4);
   logic [1:0]             live_reg;

   // Marks edges where registered outputs follow their inputs
   always_ff @(posedge clk_in) begin
      live_reg <= resetn_in ? {live_reg[0], 1'b1} : 2'h0;
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   a_one_action: assert property (
      $onehot0({graceful_shutdown_out, warm_reset_out, full_reset_out,
                forced_shutdown_out, click_cancel_out}))
      else $error("two actions at once");
   a_click_pairs: assert property (
      graceful_shutdown_out || warm_reset_out || full_reset_out |->
      $past(click_count_out) == (graceful_shutdown_out ? 3'h1 :
                                 warm_reset_out ? 3'h2 : 3'h3))
      else $error("action does not match click count");
   a_cancel_count: assert property (
      click_cancel_out |-> $past(click_count_out) == 3'h4)
      else $error("cancel without four clicks");
   a_count_max: assert property (
      click_count_out <= 3'h4)
      else $error("click count above four");
   a_forced_once: assert property (
      forced_shutdown_out |=> (!forced_shutdown_out)[*8])
      else $error("forced shutdown repeated");
   a_ctl_pair: assert property (
      board_management_controller_rst_n_out != peripheral_reset_out)
      else $error("controller and peripheral resets disagree");
   a_ctl_idle: assert property (
      (controller_reset_button_n_in && FAST)[*8] |->
      board_management_controller_rst_n_out)
      else $error("controller reset without button");
   a_ctl_pressed: assert property (
      (!controller_reset_button_n_in && FAST)[*8] |->
      !board_management_controller_rst_n_out)
      else $error("controller reset missing");
   a_boot_dsp: assert property (
      live_reg[1] |-> boot_dsp_out == DSP_MASK[$past(boot_mode_switch_in)])
      else $error("processor choice wrong for switch");
   a_debug_route: assert property (
      live_reg[1] |-> {trace_debug_header_select_out,
      onboard_emulator_connect_out} == {$past(external_debugger_detect_in),
      !$past(external_debugger_detect_in)})
      else $error("debug port routed wrongly");
   a_fan_off: assert property (
      live_reg[1] && $past(fan_duty_in) == 8'h00 &&
      $past(fan_duty_in, 2) == 8'h00 |-> !fan_pwm_out)
      else $error("fan driven at zero duty");
endmodule // bbbs_top_assertions

bind bbbs_top bbbs_top_assertions #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (
   .clk_in(clk_in), .resetn_in(resetn_in),
   .controller_reset_button_n_in(controller_reset_button_n_in),
   .boot_mode_switch_in(boot_mode_switch_in),
   .external_debugger_detect_in(external_debugger_detect_in),
   .fan_duty_in(fan_duty_in), .graceful_shutdown_out(graceful_shutdown_out),
   .warm_reset_out(warm_reset_out), .full_reset_out(full_reset_out),
   .forced_shutdown_out(forced_shutdown_out),
   .click_cancel_out(click_cancel_out), .click_count_out(click_count_out),
   .board_management_controller_rst_n_out
      (board_management_controller_rst_n_out),
   .peripheral_reset_out(peripheral_reset_out), .boot_dsp_out(boot_dsp_out),
   .onboard_emulator_connect_out(onboard_emulator_connect_out),
   .trace_debug_header_select_out(trace_debug_header_select_out),
   .fan_pwm_out(fan_pwm_out));

//--- verification/test_board_button_and_boot_select.sv
`timescale 1ns/10ps
// ============================================================
// Bench for the button and boot select block
module test_board_button_and_boot_select;
   import bbbs_pkg::*;
   logic          clk_in = 1'b0;
   logic          resetn_in = 1'b0;
   logic          press_pwr = 1'b0;
   logic          press_rst = 1'b0;
   logic          detect = 1'b0;
   logic [3:0]    sw = 4'h0;
   logic [7:0]    duty = 8'h00;
   logic [8:0]    hi;
   logic [15:0]   dsp_codes = 16'hBD02;
   logic          pb_n, rb_n, grace, warm, full, forced, cancel;
   logic          rst_n, periph, dsp, onb, hdr, pwm;
   logic [2:0]    count;
   bbbs_boot_type mode;
   int            failures = 0;
   int            num_checks = 0;
   logic [4:0]    act;
   logic [4:0]    clicks_exp [5] = '{5'h10, 5'h08, 5'h04, 5'h01, 5'h01};
   bbbs_boot_type modes [16] = '{
      BBBS_BOOT_ARM_NAND, BBBS_BOOT_DSP_NO_BOOT, BBBS_BOOT_ARM_SPI,
      BBBS_BOOT_ARM_I2C, BBBS_BOOT_ARM_UART, BBBS_BOOT_ARM_ETH,
      BBBS_BOOT_SLEEP_MAX_PLL_ARM_BYPASS, BBBS_BOOT_SLEEP_MAX_PLL,
      BBBS_BOOT_DSP_NAND, BBBS_BOOT_SLEEP_SLOW_PLL_ARM_BYPASS,
      BBBS_BOOT_DSP_SPI, BBBS_BOOT_DSP_I2C, BBBS_BOOT_DSP_UART,
      BBBS_BOOT_DSP_ETH, BBBS_BOOT_SLEEP_SLOW_PLL_SLOW_ARM_PLL,
      BBBS_BOOT_DSP_NO_BOOT};

   assign act = {grace, warm, full, forced, cancel};

   // Clock of 4 ns
   always #2 clk_in = ~clk_in;

   bbbs_panel_model u_panel (.clk_in(clk_in), .press_power_in(press_pwr),
      .press_reset_in(press_rst), .power_button_n_out(pb_n),
      .controller_reset_button_n_out(rb_n));

   bbbs_top #(.CLICK_WINDOW_CYCLES(40), .HOLD_CYCLES(200),
      .DEBOUNCE_CYCLES(4)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
      .power_button_n_in(pb_n), .controller_reset_button_n_in(rb_n),
      .boot_mode_switch_in(sw), .external_debugger_detect_in(detect),
      .fan_duty_in(duty), .graceful_shutdown_out(grace),
      .warm_reset_out(warm), .full_reset_out(full),
      .forced_shutdown_out(forced), .click_cancel_out(cancel),
      .click_count_out(count), .board_management_controller_rst_n_out(rst_n),
      .peripheral_reset_out(periph), .boot_mode_out(mode),
      .boot_dsp_out(dsp), .onboard_emulator_connect_out(onb),
      .trace_debug_header_select_out(hdr), .fan_pwm_out(pwm));

   // ============================================================
   // Shared tasks
   task automatic give_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk_mode(input bbbs_boot_type got, input bbbs_boot_type exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: boot %h want %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task automatic click(input int n, input int held);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         press_pwr <= 1'b1;
         tick(held);
         press_pwr <= 1'b0;
         tick(12);
      end
   endtask

   // First action pulse within 300 cycles, or none
   task automatic expect_act(input logic [4:0] exp);
      logic [4:0] got;
      got = 5'h00;
      for (int i = 0; i < 300 && got === 5'h00; i++) begin
         @(posedge clk_in);
         #1 got = act;
      end
      chk(got, exp);
      if (got === 5'h00 && exp !== 5'h00) give_verdict;
   endtask

   task automatic run(input int n, input int held, input logic [4:0] exp);
      fork
         click(n, held);
         expect_act(exp);
      join
   endtask

   // ============================================================
   // Main sequence
   initial begin
      tick(2);
      #1 chk({act, count, rst_n, periph, hdr, onb}, 16'h0009);
      chk_mode(mode, BBBS_BOOT_DSP_NO_BOOT);
      @(posedge clk_in);
      resetn_in <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         @(posedge clk_in);
         sw <= c[3:0];
         detect <= c[0];
         tick(2);
         #1 chk_mode(mode, modes[c]);
         chk({dsp, hdr, onb}, {13'h0000, dsp_codes[c], c[0], !c[0]});
      end
      for (int n = 1; n <= 5; n++) begin
         run(n, 12, clicks_exp[n-1]);
      end
      run(1, 60, 5'h10);
      fork
         begin
            click(1, 12);
            click(1, 250);
         end
         expect_act(5'h02);
      join
      expect_act(5'h00);
      chk(count, 16'h0000);
      for (int v = 1; v >= 0; v--) begin
         @(posedge clk_in);
         press_rst <= v[0];
         for (int i = 0; i < 30 && rst_n !== !v[0]; i++) begin
            @(posedge clk_in);
            #1;
         end
         chk({rst_n, periph}, {!v[0], v[0]});
         if (rst_n !== !v[0]) give_verdict;
      end
      for (int k = 0; k < 3; k++) begin
         @(posedge clk_in);
         duty <= 8'h7F * k[7:0];
         tick(4);
         hi = 9'h000;
         repeat (256) begin
            @(posedge clk_in);
            #1 hi = hi + pwm;
         end
         chk(hi, duty);
      end
      // Reset in mid sequence drops the pending clicks
      click(2, 12);
      #1 chk(count, 16'h0002);
      @(posedge clk_in);
      resetn_in <= 1'b0;
      tick(2);
      #1 chk({act, count}, 16'h0000);
      @(posedge clk_in);
      resetn_in <= 1'b1;
      expect_act(5'h00);
      give_verdict;
   end
endmodule // test_board_button_and_boot_select
